/* File: core/key_channel.sv */
/*
 * One key: reference tracking with separate up and down slew rates and a
 * consecutive-acquisition confirm counter.
 * Assumes raw is valid whenever sample pulses and step_tick marks 0.16 s.
 */
`timescale 1ns/1ps
module key_channel import touch_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pacing
    input wire logic sample,
    input wire logic step_tick,
    input wire logic recal,
    // Key inputs
    input wire logic enable,
    input wire logic [7:0] raw,
    input wire track_cfg_t cfg,
    // Results
    output logic touched,
    output logic half_shift
);
    logic [7:0] ref_lvl;
    logic [4:0] confirm_counter;
    logic [6:0] track_cnt;
    logic track_up;
    logic cal_pend;

    // Touch pulls the signal below the reference
    wire [8:0] fall = {1'b0, ref_lvl} - {1'b0, raw};
    wire below = !fall[8];
    wire beyond = below && fall[7:0] >= KEY_THRESHOLD;
    wire holding = below && fall[7:0] >= KEY_THRESHOLD - HYST_GAP;
    wire rising = fall[8];
    wire falling = below && fall[7:0] != 8'h00;
    wire [6:0] rate = rising ? cfg.up : cfg.down;
    // Frozen while past threshold so a real finger is never tracked away
    wire track_ok = !beyond && !touched && (rising || falling)
        && rate != 7'h00;
    wire [6:0] track_next = 7'(track_cnt + 7'h01);

    assign half_shift = below && fall[7:0] > (KEY_THRESHOLD >> 1);

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            ref_lvl <= 8'h00;
            confirm_counter <= 5'h00;
            track_cnt <= 7'h00;
            track_up <= 1'b0;
            touched <= 1'b0;
            cal_pend <= 1'b1;
        end else if (sample && cal_pend) begin
            ref_lvl <= raw;
            confirm_counter <= 5'h00;
            touched <= 1'b0;
            cal_pend <= 1'b0;
        end else begin
            if (recal) begin
                cal_pend <= 1'b1;
            end
            if (sample) begin
                if (touched) begin
                    touched <= holding;
                    confirm_counter <= 5'h00;
                end else if (beyond) begin
                    // Limit is the setting plus one built-in count
                    if (confirm_counter >= cfg.extra) begin
                        touched <= 1'b1;
                    end
                    if (confirm_counter != 5'h1f) begin
                        confirm_counter <= confirm_counter + 5'h01;
                    end
                end else begin
                    confirm_counter <= 5'h00;
                end
            end
            if (step_tick) begin
                if (!track_ok || track_up != rising) begin
                    track_cnt <= 7'h00;
                    track_up <= rising;
                end else if (track_next >= rate) begin
                    track_cnt <= 7'h00;
                    ref_lvl <= rising ? ref_lvl + 8'h01
                                      : ref_lvl - 8'h01;
                end else begin
                    track_cnt <= track_next;
                end
            end
        end
    end
endmodule : key_channel

/* File: core/touch_pkg.sv */
/*
 * Shared constants and types of the touch status and acquisition block.
 * Assumes a 100 MHz system clock; CYCLE_CLKS below derives from it.
 */
package touch_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int CYCLE_MS = 16;
    localparam int CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;
    localparam int STEP_MS = 160;
    localparam int STEP_TICKS = STEP_MS / CYCLE_MS;

    localparam logic [6:0] BUS_ADDR = 7'h0d;

    localparam logic [7:0] ADDR_IDENT = 8'h00;
    localparam logic [7:0] ADDR_VERSION = 8'h01;
    localparam logic [7:0] ADDR_FLAGS = 8'h02;
    localparam logic [7:0] ADDR_KEYS_LO = 8'h03;
    localparam logic [7:0] ADDR_KEYS_HI = 8'h04;
    localparam logic [7:0] ADDR_STRIP = 8'h05;
    localparam logic [7:0] ADDR_PINS = 8'h06;
    localparam logic [7:0] ADDR_SUBVER = 8'h07;
    localparam logic [7:0] ADDR_RECAL = 8'h0a;
    localparam logic [7:0] ADDR_RESTART = 8'h0b;
    localparam logic [7:0] ADDR_SLEEP = 8'h0c;
    localparam logic [7:0] ADDR_REPEAT = 8'h0d;
    localparam logic [7:0] ADDR_DOWN = 8'h0f;
    localparam logic [7:0] ADDR_UP = 8'h10;
    localparam logic [7:0] ADDR_CONFIRM = 8'h11;
    localparam logic [7:0] ADDR_LAST = 8'hff;

    localparam logic [7:0] RST_SLEEP = 8'h01;
    localparam logic [5:0] RST_REPEAT = 6'h01;
    localparam logic [6:0] RST_DOWN = 7'h14;
    localparam logic [6:0] RST_UP = 7'h05;
    localparam logic [4:0] RST_CONFIRM = 5'h03;

    localparam int PIN_LSB = 2;
    localparam int STATUS_BYTES = 5;
    localparam logic [7:0] KEY_THRESHOLD = 8'h0a;
    localparam logic [7:0] HYST_GAP = 8'h02;

    typedef struct packed {
        logic reset_seen;
        logic overrun;
        logic [3:0] zero;
        logic all_keys_shift_flag;
        logic strip_touch_flag;
    } flags_t;

    typedef struct packed {
        logic [6:0] down;
        logic [6:0] up;
        logic [4:0] extra;
    } track_cfg_t;
endpackage : touch_pkg

/* File: core/touch_status_core.sv */
/*
 * Status and acquisition control of a 16-key touch controller: serial
 * register slave, status bytes with change pin, acquisition pacing,
 * command bytes and sixteen key channels.
 * Assumes the front end returns one acq_done pulse per acq_start with
 * key_raw valid in that cycle; slider and pin direction come from
 * same-clock logic; scl_in, sda_in and gpio_in are asynchronous pins.
 */
//
// Contract
// - Fixed read-only identity byte at address zero
// - Version byte: major high nibble, minor low
// - Any status byte change asserts change pin
// - Flag bit 7 set on reset, cleared by read
// - Flag bit 6 shows cycle time over 16 ms
// - Flag bit 1: all selected keys shifted half
// - Flag bit 0 shows slider touch now
// - Addresses 3 and 4 hold key touch bits
// - Address 5 holds last slider position
// - Pin byte bits 4..2 show input pins
// - Input pins sampled once per 16 ms cycle
// - Nonzero write to 10 starts recalibration
// - Nonzero write to 11 resets the device
// - Mute bus and change, reset 16 ms later
// - Sleep interval counts 16 ms steps, default 1
// - Sleep interval zero stops all measurement
// - Average 1 to 63 bursts; host never writes 0
// - Reference slews toward signal, separate rates
// - No tracking while past touch threshold
// - Rate zero disables; defaults 20 and 5
// - Confirm counter counts, clears, declares touch
// - Limit is setting plus one, default 3
// - Change pin held until changed bytes read
// - Register address advances after each byte
`timescale 1ns/1ps
module touch_status_core import touch_pkg::*; #(
    parameter int CYCLE_CLKS_P = CYCLE_CLKS,
    parameter logic [7:0] PART_ID = 8'h5a,      // Arbitrary value
    parameter logic [3:0] VER_MAJOR = 4'h1,
    parameter logic [3:0] VER_MINOR = 4'h0,
    parameter logic [7:0] SUB_VERSION = 8'h00,
    parameter logic [6:0] DEV_ADDR = BUS_ADDR
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Change pin, active low open drain
    output logic change_out,
    output logic change_oe,
    // Acquisition front end
    output logic acq_start,
    output logic recal_req,
    output logic [5:0] measure_repeat_count,
    input wire logic acq_done,
    input wire logic [15:0][7:0] key_raw,
    input wire logic [15:0] key_enable,
    input wire logic [15:0] shift_select,
    // Slider logic
    input wire logic strip_touch,
    input wire logic [7:0] strip_pos,
    // General pins
    input wire logic [2:0] gpio_in,
    input wire logic [2:0] gpio_is_input
);
    localparam int OVR_W = $clog2(CYCLE_CLKS_P) + 1;

    if (CYCLE_CLKS_P < 16) begin : g_bad_cycle
        $error("CYCLE_CLKS_P too small");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK
    } bus_state_t;
    typedef enum logic [1:0] {PH_SLA, PH_MEM, PH_DATA} phase_t;

    logic rst_all;
    logic soft_rst;

    // Pin synchronisers; logic reads the second stage and, for the bus pins, its one-clock delayed copy
    logic [1:0] scl_sync, sda_sync;
    logic scl_d, sda_d;
    logic [2:0] gpio_meta, gpio_sync;

    always_ff @(posedge clk) begin
        if (srst) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            gpio_meta <= 3'h0;
            gpio_sync <= 3'h0;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
            gpio_meta <= gpio_in;
            gpio_sync <= gpio_meta;
        end
    end

    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire bus_start = scl_s && scl_d && sda_d && !sda_s;
    wire bus_stop = scl_s && scl_d && !sda_d && sda_s;
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;

    // Serial slave
    bus_state_t state;
    phase_t phase;
    logic [2:0] bit_cnt;
    logic got8;
    logic rw;
    logic [7:0] shreg, txsh, ptr, rd_data;
    logic muted;

    wire sla_match = shreg[7:1] == DEV_ADDR && !muted;
    wire rx_byte = state == ST_RX && scl_fall && got8;
    wire wr_fire = rx_byte && phase == PH_DATA;
    wire mem_fire = rx_byte && phase == PH_MEM;
    wire rd_fire = state == ST_ACK && scl_fall && rw;
    wire tx_done = state == ST_TX && scl_fall && bit_cnt == 3'h7;

    always_ff @(posedge clk) begin
        if (rst_all || bus_stop) begin
            state <= ST_IDLE;
            phase <= PH_SLA;
            bit_cnt <= 3'h0;
            got8 <= 1'b0;
            rw <= 1'b0;
            shreg <= 8'h00;
            txsh <= 8'h00;
            sda_oe <= 1'b0;
        end else if (bus_start) begin
            state <= ST_RX;
            phase <= PH_SLA;
            bit_cnt <= 3'h0;
            got8 <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 3'h1;
                        got8 <= bit_cnt == 3'h7;
                    end else if (rx_byte) begin
                        got8 <= 1'b0;
                        if (phase == PH_SLA && !sla_match) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_ACK;
                            sda_oe <= 1'b1;
                        end
                        if (phase == PH_SLA) begin
                            rw <= shreg[0];
                            phase <= PH_MEM;
                        end else begin
                            phase <= PH_DATA;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 3'h0;
                        if (rw) begin
                            state <= ST_TX;
                            txsh <= {rd_data[6:0], 1'b0};
                            sda_oe <= !rd_data[7];
                        end else begin
                            state <= ST_RX;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (tx_done) begin
                        state <= ST_RACK;
                        sda_oe <= 1'b0;
                    end else if (scl_fall) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        txsh <= {txsh[6:0], 1'b0};
                        sda_oe <= !txsh[7];
                    end
                end
                ST_RACK: begin
                    // Master acknowledge asks for the next byte
                    if (scl_rise) begin
                        state <= sda_s ? ST_IDLE : ST_ACK;
                    end
                end
            endcase
        end
    end

    // Address pointer stops at the top of the map
    always_ff @(posedge clk) begin
        if (rst_all) begin
            ptr <= 8'h00;
        end else if (mem_fire) begin
            ptr <= shreg;
        end else if ((wr_fire || tx_done) && ptr != ADDR_LAST) begin
            ptr <= ptr + 8'h01;
        end
    end

    // Configuration registers
    logic [7:0] recal_cfg, restart_cfg, sleep_interval;
    logic [6:0] downward_track_rate, upward_track_rate;
    logic [4:0] confirm_count_extra;

    wire wr_nonzero = wr_fire && shreg != 8'h00;
    wire restart_hit = wr_nonzero && ptr == ADDR_RESTART;

    always_ff @(posedge clk) begin
        if (rst_all) begin
            recal_cfg <= 8'h00;
            restart_cfg <= 8'h00;
            sleep_interval <= RST_SLEEP;
            measure_repeat_count <= RST_REPEAT;
            downward_track_rate <= RST_DOWN;
            upward_track_rate <= RST_UP;
            confirm_count_extra <= RST_CONFIRM;
            recal_req <= 1'b0;
        end else begin
            recal_req <= wr_nonzero && ptr == ADDR_RECAL;
            if (wr_fire) begin
                case (ptr)
                    ADDR_RECAL: recal_cfg <= shreg;
                    ADDR_RESTART: restart_cfg <= shreg;
                    ADDR_SLEEP: sleep_interval <= shreg;
                    ADDR_REPEAT: measure_repeat_count <= shreg[5:0];
                    ADDR_DOWN: downward_track_rate <= shreg[6:0];
                    ADDR_UP: upward_track_rate <= shreg[6:0];
                    ADDR_CONFIRM: confirm_count_extra <= shreg[4:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Restart sequence runs on the pin reset only, so it survives itself
    logic [1:0] restart_stage;
    logic cycle_tick;

    always_ff @(posedge clk) begin
        if (srst) begin
            restart_stage <= 2'h0;
            muted <= 1'b0;
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= 1'b0;
            if (restart_stage == 2'h0 && restart_hit) begin
                restart_stage <= 2'h1;
            end else if (restart_stage == 2'h1 && cycle_tick) begin
                restart_stage <= 2'h2;
                muted <= 1'b1;
            end else if (restart_stage == 2'h2 && cycle_tick) begin
                restart_stage <= 2'h0;
                muted <= 1'b0;
                soft_rst <= 1'b1;
            end
        end
    end

    assign rst_all = srst || soft_rst;

    // Acquisition pacing
    logic [OVR_W-1:0] cyc_cnt, busy_cnt;
    logic [7:0] sleep_cnt;
    logic [3:0] step_cnt;
    logic busy;

    assign cycle_tick = cyc_cnt == OVR_W'(CYCLE_CLKS_P - 1);
    wire step_tick = cycle_tick && step_cnt == 4'(STEP_TICKS - 1);
    wire sleep_due = sleep_interval != 8'h00
        && 8'(sleep_cnt + 8'h01) >= sleep_interval;

    always_ff @(posedge clk) begin
        if (rst_all) begin
            cyc_cnt <= '0;
            sleep_cnt <= 8'h00;
            step_cnt <= 4'h0;
            acq_start <= 1'b0;
        end else begin
            cyc_cnt <= cycle_tick ? '0 : cyc_cnt + OVR_W'(1);
            acq_start <= cycle_tick && sleep_due;
            if (cycle_tick) begin
                sleep_cnt <= sleep_due ? 8'h00 : sleep_cnt + 8'h01;
                step_cnt <= step_tick ? 4'h0 : step_cnt + 4'h1;
            end
        end
    end

    // Key channels
    logic [15:0] key_touch_bit, key_half;
    track_cfg_t track_cfg;

    assign track_cfg = '{down: downward_track_rate, up: upward_track_rate,
                         extra: confirm_count_extra};

    for (genvar k = 0; k < 16; k++) begin : g_key
        key_channel u_key (
            .clk(clk),
            .rst(rst_all),
            .sample(acq_done),
            .step_tick(step_tick),
            .recal(recal_req),
            .enable(key_enable[k]),
            .raw(key_raw[k]),
            .cfg(track_cfg),
            .touched(key_touch_bit[k]),
            .half_shift(key_half[k])
        );
    end

    // Status bytes
    flags_t flags;
    logic [7:0] strip_location, pin_snap;
    wire read_flags = rd_fire && ptr == ADDR_FLAGS;
    // Unselected keys count as shifted, so an empty group reads 1
    wire all_shift = &(key_half | ~shift_select);

    always_ff @(posedge clk) begin
        if (rst_all) begin
            flags <= '0;
            flags.reset_seen <= 1'b1;
            busy <= 1'b0;
            busy_cnt <= '0;
            strip_location <= 8'h00;
            pin_snap <= 8'h00;
        end else begin
            if (read_flags) begin
                flags.reset_seen <= 1'b0;
            end
            if (acq_start) begin
                busy <= 1'b1;
                busy_cnt <= '0;
            end else if (busy && busy_cnt != OVR_W'(CYCLE_CLKS_P)) begin
                busy_cnt <= busy_cnt + OVR_W'(1);
            end
            if (busy && busy_cnt == OVR_W'(CYCLE_CLKS_P)) begin
                flags.overrun <= 1'b1;
            end
            if (acq_done) begin
                busy <= 1'b0;
                if (busy && busy_cnt < OVR_W'(CYCLE_CLKS_P)) begin
                    flags.overrun <= 1'b0;
                end
                flags.all_keys_shift_flag <= all_shift;
                flags.strip_touch_flag <= strip_touch;
                if (strip_touch) begin
                    strip_location <= strip_pos;
                end
            end
            if (cycle_tick) begin
                // Pins are looked at once per cycle, outputs read 0
                pin_snap <= 8'({5'h00, gpio_sync & gpio_is_input}
                    << PIN_LSB);
            end
        end
    end

    // Change tracking: a byte stays pending until the host reads it
    logic [STATUS_BYTES-1:0][7:0] status_now, status_prev;
    logic [STATUS_BYTES-1:0] pending, changed, read_clr;

    assign status_now = {pin_snap, strip_location, key_touch_bit[15:8],
                         key_touch_bit[7:0], flags};

    always_comb begin
        for (int i = 0; i < STATUS_BYTES; i++) begin
            changed[i] = status_now[i] != status_prev[i];
            read_clr[i] = rd_fire && ptr == 8'(ADDR_FLAGS + 8'(i));
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            status_prev <= '0;
            pending <= '0;
            change_oe <= 1'b0;
            change_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            status_prev <= status_now;
            // A change in the cycle of its read keeps the byte pending
            pending <= (pending & ~read_clr) | changed;
            change_oe <= |pending && !muted;
            change_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // Read selection; unlisted addresses read zero
    always_comb begin
        case (ptr)
            ADDR_IDENT: rd_data = PART_ID;
            ADDR_VERSION: rd_data = {VER_MAJOR, VER_MINOR};
            ADDR_FLAGS: rd_data = flags;
            ADDR_KEYS_LO: rd_data = key_touch_bit[7:0];
            ADDR_KEYS_HI: rd_data = key_touch_bit[15:8];
            ADDR_STRIP: rd_data = strip_location;
            ADDR_PINS: rd_data = pin_snap;
            ADDR_SUBVER: rd_data = SUB_VERSION;
            ADDR_RECAL: rd_data = recal_cfg;
            ADDR_RESTART: rd_data = restart_cfg;
            ADDR_SLEEP: rd_data = sleep_interval;
            ADDR_REPEAT: rd_data = {2'b00, measure_repeat_count};
            ADDR_DOWN: rd_data = {1'b0, downward_track_rate};
            ADDR_UP: rd_data = {1'b0, upward_track_rate};
            ADDR_CONFIRM: rd_data = {3'b000, confirm_count_extra};
            default: rd_data = 8'h00;
        endcase
    end
endmodule : touch_status_core

/* File: tb/host_master.sv */
/* Host bus master model, 160 ns bus clock.
   Assumes a pull-up on data; dev_low is the core's pull-down. */
`timescale 1ns/1ps
module host_master import touch_pkg::*; (
    // Clock
    input wire logic clk,
    // Bus lines
    input wire logic dev_low,
    output logic scl,
    output logic sda
);
    logic low = 1'b0;
    // Clock stands high between frames
    initial scl = 1'b1;
    assign sda = !(low || dev_low);
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    // Data moves mid-low so no false start is seen
    task bitx(input logic b, output logic r);
        wt(4);
        low = !b;
        wt(4);
        scl = 1'b1;
        wt(8);
        r = sda;
        scl = 1'b0;
    endtask : bitx
    task octet(input logic [7:0] d, input logic last, output logic [7:0] q,
               output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(last, a);
        ack = !a;
    endtask : octet
    task start();
        wt(4);
        low = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(8);
        low = 1'b1;
        wt(8);
        scl = 1'b0;
    endtask : start
    task stop();
        wt(4);
        low = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(8);
        low = 1'b0;
        wt(8);
    endtask : stop
    task xfer(input logic [7:0] a, input logic rd, input int n,
              input logic [15:0] wd, output logic [15:0] q, output logic ok);
        logic [7:0] b;
        logic k;
        q = 16'h0000;
        start();
        octet({BUS_ADDR, 1'b0}, 1'b1, b, ok);
        if (ok)
            octet(a, 1'b1, b, k);
        for (int i = n - 1; ok && !rd && i >= 0; i--)
            octet(wd[8*i +: 8], 1'b1, b, k);
        stop();
        if (ok && rd) begin
            start();
            octet({BUS_ADDR, 1'b1}, 1'b1, b, k);
            for (int i = n - 1; i >= 0; i--) begin
                octet(8'hff, i == 0, b, k);
                q[8*i +: 8] = b;
            end
            stop();
        end
    endtask : xfer
endmodule : host_master

/* File: tb/test_touch_status_core.sv */
/* Bench of the touch core: host model, one-clock front end, sequences.
   Assumes the core paces on a shortened 1024-clock cycle. */
`timescale 1ns/1ps
module test_touch_status_core import touch_pkg::*;;
    localparam int CYC = 1024;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic scl, sda, oe, chg, acq, recal, so, co, done = 1'b0;
    logic [5:0] reps;
    logic [15:0][7:0] raw = {16{8'h80}};
    logic [15:0] sel = 16'h0001, en = 16'hffff;
    logic st = 1'b0;
    logic [7:0] pos = 8'h00;
    logic [2:0] gin = 3'b101, dir = 3'b011;
    logic [15:0] q;
    logic ok;
    int fails = 0, checks = 0, recals = 0, gap;
    touch_status_core #(.CYCLE_CLKS_P(CYC), .PART_ID(8'h66), // Arbitrary id
        .VER_MAJOR(4'h2), .VER_MINOR(4'h7)) dut (
        .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(so),
        .sda_oe(oe), .change_out(co), .change_oe(chg), .acq_start(acq),
        .recal_req(recal), .measure_repeat_count(reps), .acq_done(done),
        .key_raw(raw), .key_enable(en), .shift_select(sel),
        .strip_touch(st), .strip_pos(pos), .gpio_in(gin),
        .gpio_is_input(dir));
    host_master host (.clk(clk), .dev_low(oe), .scl(scl), .sda(sda));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        done <= #1 acq;
        if (recal === 1'b1)
            recals++;
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR %0t: got %h, want %h", $time, s, e);
        end
    endtask : chk
    task rdn(input logic [7:0] a, input int n, input logic [15:0] e);
        host.xfer(a, 1'b1, n, 16'h0000, q, ok);
        chk(q[15:8], e[15:8]);
        chk(q[7:0], e[7:0]);
    endtask : rdn
    task wr(input logic [7:0] a, input int n, input logic [15:0] d);
        host.xfer(a, 1'b0, n, d, q, ok);
    endtask : wr
    task next_acq();
        gap = 0;
        do begin
            host.wt(1);
            gap++;
        end while (acq !== 1'b1 && gap < 8 * CYC);
        if (gap >= 8 * CYC) begin
            fails++;
            report_and_stop();
        end
    endtask : next_acq
    task report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    initial begin
        host.wt(16);
        srst = 1'b0;
        rdn(ADDR_FLAGS, 2, 16'h8000);
        rdn(ADDR_FLAGS, 1, 16'h0000);
        chk({7'h0, chg}, 8'h01);
        rdn(ADDR_PINS, 1, 16'h0004);
        host.wt(4);
        chk({7'h0, chg}, 8'h00);
        rdn(ADDR_IDENT, 2, 16'h6627);
        wr(ADDR_IDENT, 1, 16'h00ff);
        rdn(ADDR_IDENT, 1, 16'h0066);
        rdn(ADDR_SLEEP, 2, 16'h0101);
        rdn(ADDR_DOWN, 2, 16'h1405);
        rdn(ADDR_CONFIRM, 1, 16'h0003);
        $display("test reset done");
        wr(ADDR_SLEEP, 2, 16'h0305);
        chk({2'b00, reps}, 8'h05);
        next_acq();
        next_acq();
        chk(8'(gap - 3 * CYC), 8'h00);
        wr(ADDR_SLEEP, 1, 16'h0000);
        gap = 0;
        repeat (3 * CYC) begin
            host.wt(1);
            gap += int'(acq === 1'b1);
        end
        chk(8'(gap), 8'h00);
        wr(ADDR_SLEEP, 1, 16'h0001);
        wr(ADDR_RECAL, 1, 16'h0000);
        chk(8'(recals), 8'h00);
        wr(ADDR_RECAL, 1, 16'h0080);
        chk(8'(recals), 8'h01);
        $display("test pacing done");
        wr(ADDR_CONFIRM, 1, 16'h0001);
        // Let the recalibration take its reference first
        host.wt(2 * CYC);
        raw[9] = 8'h70;
        raw[10] = 8'h70;
        sel = 16'h0200;
        host.wt(4 * CYC);
        chk({7'h0, chg}, 8'h01);
        en = 16'hfbff;
        rdn(ADDR_FLAGS, 2, 16'h0200);
        rdn(ADDR_KEYS_HI, 1, 16'h0002);
        host.wt(4);
        chk({7'h0, chg}, 8'h00);
        raw[9] = 8'h80;
        st = 1'b1;
        pos = 8'h3c;
        host.wt(4 * CYC);
        rdn(ADDR_FLAGS, 1, 16'h0001);
        rdn(ADDR_KEYS_HI, 2, 16'h003c);
        st = 1'b0;
        pos = 8'h11;
        host.wt(2 * CYC);
        rdn(ADDR_FLAGS, 1, 16'h0000);
        rdn(ADDR_STRIP, 1, 16'h003c);
        $display("test keys done");
        next_acq();
        gin = 3'b110;
        dir = 3'b111;
        rdn(ADDR_PINS, 1, 16'h0004);
        host.wt(CYC);
        rdn(ADDR_PINS, 1, 16'h0018);
        wr(ADDR_RESTART, 1, 16'h0001);
        next_acq();
        host.wt(8);
        chk({5'h0, so, co, chg}, 8'h00);
        host.xfer(ADDR_IDENT, 1'b1, 1, 16'h0000, q, ok);
        chk({7'h0, ok}, 8'h00);
        host.wt(2 * CYC);
        rdn(ADDR_SLEEP, 2, 16'h0101);
        chk({2'b00, reps}, 8'h01);
        $display("test restart done");
        report_and_stop();
    end
endmodule : test_touch_status_core

/* File: tb/touch_chk_sva.sv */
/* Port assertions of the touch core.
   Assumes one clock domain with srst. */
`timescale 1ns/1ps
module touch_chk import touch_pkg::*; (
    // Watched ports
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_oe,
    input wire logic change_oe,
    input wire logic acq_start,
    input wire logic recal_req,
    input wire logic [5:0] measure_repeat_count
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    reset_quiet_a: assert property ($fell(srst) |-> !sda_oe && !acq_start)
        else $error("busy after reset");
    repeat_default_a: assert property ($fell(srst) |-> measure_repeat_count == 6'h01)
        else $error("bad repeat default");
    reset_change_a: assert property ($fell(srst) |-> ##[1:3] change_oe)
        else $error("no change after reset");
    start_pulse_a: assert property (acq_start |=> !acq_start [*8])
        else $error("starts too close");
    recal_pulse_a: assert property (recal_req |=> !recal_req)
        else $error("recal pulse too long");
    recal_ack_a: assert property (recal_req |-> ##[0:6] sda_oe)
        else $error("recal outside a write");
    bus_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data moved with clock high");
    bit_setup_a: assert property ($rose(sda_oe) |-> ##[1:8] scl_in)
        else $error("data driven late");
    cover property (acq_start);
    cover property (recal_req);
    cover property ($fell(change_oe));
endmodule : touch_chk
bind touch_status_core touch_chk chk (.clk(clk), .srst(srst),
    .scl_in(scl_in), .sda_oe(sda_oe), .change_oe(change_oe),
    .acq_start(acq_start), .recal_req(recal_req),
    .measure_repeat_count(measure_repeat_count));
